//--- src/rom_link.sv
// Purpose: Pin bundle between ROM devices and their controller
// Assumes: One controller, N_DEV devices on one data line
// Notes:   Undriven data line reads high, as with a pull-up
`timescale 1ns/100ps
interface rom_link #(
  parameter int N_DEV = 1
) ();
  logic             horiz_serial_addr_in;
  logic             vert_serial_addr_in;
  logic             horiz_addr_strobe;
  logic             vert_addr_strobe;
  logic             addr_transfer_strobe_n;
  logic             read_clock_n;
  logic [N_DEV-1:0] cs_n;
  logic             dout_o  [N_DEV];
  logic             dout_oe [N_DEV];
  logic             data_line;

  // ==========================================================
  // Shared line resolution
  always_comb begin
    data_line = 1'b1;
    for (int i = 0; i < N_DEV; i++) begin
      if (dout_oe[i]) begin
        data_line = dout_o[i];
      end
    end
  end

  modport device (
    input  horiz_serial_addr_in, vert_serial_addr_in, horiz_addr_strobe, vert_addr_strobe,
    input  addr_transfer_strobe_n, read_clock_n, cs_n,
    output dout_o, dout_oe
  );
  modport controller (
    output horiz_serial_addr_in, vert_serial_addr_in, horiz_addr_strobe, vert_addr_strobe,
    output addr_transfer_strobe_n, read_clock_n, cs_n,
    input  data_line
  );
endinterface

//--- src/rom_playback_ctrl.sv
// Purpose: Controller that loads a start address and streams bytes out of a serial ROM
// Assumes: Devices sample pins on clk_sys; one command at a time
// Notes:   Bits pack LSB first into bytes; a full FIFO stalls the read clock
`timescale 1ns/100ps
module stream_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rstn,
  // Fill side
  input  wire logic             in_valid,
  output wire logic             in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output wire logic             out_valid,
  input  wire logic             out_ready,
  output wire logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW:0]      wr_ptr;
  logic [PW:0]      rd_ptr;
  logic [PW:0]      next_wr_ptr;
  logic [PW:0]      next_rd_ptr;
  logic             full;
  logic             empty;

  // ==========================================================
  // Pointers
  always_comb begin
    full        = (wr_ptr[PW] != rd_ptr[PW]) && (wr_ptr[PW-1:0] == rd_ptr[PW-1:0]);
    empty       = (wr_ptr == rd_ptr);
    next_wr_ptr = (in_valid && !full) ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = (out_ready && !empty) ? rd_ptr + 1'b1 : rd_ptr;
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
  end

  // Storage has no reset; empty guards its contents
  always_ff @(posedge clk_sys) begin
    if (in_valid && !full) begin
      mem[wr_ptr[PW-1:0]] <= in_data;
    end
  end

  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem[rd_ptr[PW-1:0]];
endmodule

module rom_playback_ctrl
  import rom_reader_pkg::*;
#(
  parameter int N_DEV      = 1,
  parameter int FIFO_DEPTH = 32,
  parameter int DEV_W      = (N_DEV > 1) ? $clog2(N_DEV) : 1
) (
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rstn,
  // Command
  input  wire logic              cmd_valid,
  output wire logic              cmd_ready,
  input  wire logic [ADDR_W-1:0] cmd_addr,
  input  wire logic [LEN_W-1:0]  cmd_len,
  input  wire logic [DEV_W-1:0]  cmd_dev,
  // Byte stream
  output wire logic              out_valid,
  input  wire logic              out_ready,
  output wire logic [BYTE_W-1:0] out_data,
  // Status
  output wire logic              busy,
  // Pins
  rom_link.controller            link
);

  ctrl_state_t        state;
  ctrl_state_t        next_state;
  logic [TIMER_W-1:0] timer;
  logic [TIMER_W-1:0] next_timer;
  logic [HALF_W-1:0]  haddr;
  logic [HALF_W-1:0]  vaddr;
  logic [HALF_W-1:0]  next_haddr;
  logic [HALF_W-1:0]  next_vaddr;
  logic [3:0]         bit_idx;
  logic [3:0]         next_bit_idx;
  logic [LEN_W-1:0]   remain;
  logic [LEN_W-1:0]   next_remain;
  logic [DEV_W-1:0]   dev;
  logic [DEV_W-1:0]   next_dev;
  logic               active;
  logic               next_active;
  logic [BYTE_W-1:0]  shreg;
  logic [BYTE_W-1:0]  next_shreg;
  logic [2:0]         bit_cnt;
  logic [2:0]         next_bit_cnt;
  logic               pending;
  logic               next_pending;
  logic               fifo_ready;
  logic               done;

  // ==========================================================
  // Sequencer
  always_comb begin
    done         = (timer == '0);
    next_state   = state;
    next_timer   = done ? timer : timer - 1'b1;
    next_haddr   = haddr;
    next_vaddr   = vaddr;
    next_bit_idx = bit_idx;
    next_remain  = remain;
    next_dev     = dev;
    next_active  = active;
    next_shreg   = shreg;
    next_bit_cnt = bit_cnt;
    next_pending = pending && !fifo_ready;
    case (state)
      ST_IDLE: begin
        if (cmd_valid) begin
          next_haddr   = cmd_addr[HALF_W-1:0];
          next_vaddr   = cmd_addr[ADDR_W-1:HALF_W];
          next_remain  = cmd_len;
          next_dev     = cmd_dev;
          next_active  = 1'b1;
          next_bit_idx = 4'h0;
          next_bit_cnt = 3'h0;
          next_timer   = CSS_CYC - 1'b1;
          next_state   = ST_CS_SETUP;
        end
      end
      ST_CS_SETUP: begin
        if (done) begin
          next_timer = AS_CYC - 1'b1;
          next_state = ST_ADDR_SETUP;
        end
      end
      ST_ADDR_SETUP: begin
        if (done) begin
          next_timer = SAS_CYC - 1'b1;
          next_state = ST_STROBE_HIGH;
        end
      end
      ST_STROBE_HIGH: begin
        if (done) begin
          next_timer = SAP_CYC - 1'b1;
          next_state = ST_STROBE_LOW;
        end
      end
      ST_STROBE_LOW: begin
        if (done) begin
          if (bit_idx == LAST_BIT) begin
            next_timer = ATS_CYC - 1'b1;
            next_state = ST_XFER_SETUP;
          end else begin
            // Shift only after the low phase, which covers address hold
            next_haddr   = haddr >> 1;
            next_vaddr   = vaddr >> 1;
            next_bit_idx = bit_idx + 4'h1;
            next_timer   = AS_CYC - 1'b1;
            next_state   = ST_ADDR_SETUP;
          end
        end
      end
      ST_XFER_SETUP: begin
        if (done) begin
          next_timer = TAS_CYC - 1'b1;
          next_state = ST_XFER_LOW;
        end
      end
      ST_XFER_LOW: begin
        if (done) begin
          next_timer = TRS_CYC - 1'b1;
          next_state = ST_READ_SETUP;
        end
      end
      ST_READ_SETUP, ST_READ_HIGH: begin
        if (done) begin
          if (remain == '0) begin
            next_active = 1'b0;
            next_state  = ST_IDLE;
          end else if (!pending) begin
            // Back-pressure: a byte waiting for the FIFO holds the clock high
            next_timer = RD_CYC - 1'b1;
            next_state = ST_READ_LOW;
          end
        end
      end
      ST_READ_LOW: begin
        if (done) begin
          // Sampled at the end of the low phase, after access time
          next_shreg   = {link.data_line, shreg[BYTE_W-1:1]};
          next_bit_cnt = bit_cnt + 3'h1;
          if (bit_cnt == 3'h7) begin
            next_pending = 1'b1;
            next_remain  = remain - 1'b1;
          end
          next_timer = RDP_CYC - 1'b1;
          next_state = ST_READ_HIGH;
        end
      end
      default: begin
        next_active = 1'b0;
        next_state  = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state   <= ST_IDLE;
      timer   <= '0;
      haddr   <= HALF_RST;
      vaddr   <= HALF_RST;
      bit_idx <= 4'h0;
      remain  <= '0;
      dev     <= '0;
      active  <= 1'b0;
      shreg   <= '0;
      bit_cnt <= 3'h0;
      pending <= 1'b0;
    end else begin
      state   <= next_state;
      timer   <= next_timer;
      haddr   <= next_haddr;
      vaddr   <= next_vaddr;
      bit_idx <= next_bit_idx;
      remain  <= next_remain;
      dev     <= next_dev;
      active  <= next_active;
      shreg   <= next_shreg;
      bit_cnt <= next_bit_cnt;
      pending <= next_pending;
    end
  end

  // ==========================================================
  // Pins
  assign link.horiz_serial_addr_in   = haddr[0];
  assign link.vert_serial_addr_in    = vaddr[0];
  assign link.horiz_addr_strobe      = (state == ST_STROBE_HIGH);
  assign link.vert_addr_strobe       = (state == ST_STROBE_HIGH);
  assign link.addr_transfer_strobe_n = (state != ST_XFER_LOW);
  assign link.read_clock_n           = (state != ST_READ_LOW);

  // At most one select low at a time
  always_comb begin
    for (int i = 0; i < N_DEV; i++) begin
      link.cs_n[i] = !(active && (dev == DEV_W'(i)));
    end
  end

  // ==========================================================
  // Byte buffer
  stream_fifo #(
    .WIDTH (BYTE_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .rstn      (rstn),
    .in_valid  (pending),
    .in_ready  (fifo_ready),
    .in_data   (shreg),
    .out_valid (out_valid),
    .out_ready (out_ready),
    .out_data  (out_data)
  );

  assign cmd_ready = (state == ST_IDLE);
  assign busy      = active;

endmodule

//--- src/rom_reader_pkg.sv
// Purpose: Shared constants for the serial ROM reader and its controller
// Assumes: clk_sys at 100 MHz
// Notes:   Pin timing minima rounded up to whole cycles
package rom_reader_pkg;

  // ==========================================================
  // Geometry
  localparam int HALF_W   = 10;
  localparam int ADDR_W   = 2 * HALF_W;
  localparam int BYTE_W   = 8;
  localparam int LEN_W    = 16;
  localparam int TIMER_W  = 8;

  // ==========================================================
  // Clock
  localparam int CLK_NS   = 10;

  // ==========================================================
  // Pin timing in ns, least values
  localparam int T_CSS_NS = 1000;
  localparam int T_AS_NS  = 100;
  localparam int T_SAS_NS = 250;
  localparam int T_SAP_NS = 250;
  localparam int T_ATS_NS = 500;
  localparam int T_TAS_NS = 250;
  localparam int T_TRS_NS = 500;
  localparam int T_RD_NS  = 1500;
  localparam int T_RDP_NS = 1000;

  // ==========================================================
  // Timing in cycles, rounded up
  localparam logic [TIMER_W-1:0] CSS_CYC = TIMER_W'((T_CSS_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [TIMER_W-1:0] AS_CYC  = TIMER_W'((T_AS_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [TIMER_W-1:0] SAS_CYC = TIMER_W'((T_SAS_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [TIMER_W-1:0] SAP_CYC = TIMER_W'((T_SAP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [TIMER_W-1:0] ATS_CYC = TIMER_W'((T_ATS_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [TIMER_W-1:0] TAS_CYC = TIMER_W'((T_TAS_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [TIMER_W-1:0] TRS_CYC = TIMER_W'((T_TRS_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [TIMER_W-1:0] RD_CYC  = TIMER_W'((T_RD_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [TIMER_W-1:0] RDP_CYC = TIMER_W'((T_RDP_NS + CLK_NS - 1) / CLK_NS);

  // ==========================================================
  // Reset values and last address bit index
  localparam logic [ADDR_W-1:0] ADDR_RST = 20'h00000;
  localparam logic [HALF_W-1:0] HALF_RST = 10'h000;
  localparam logic [3:0]        LAST_BIT = 4'h9;

  // ==========================================================
  // Controller states, Gray along the first pass from ST_IDLE to ST_READ_HIGH
  typedef enum logic [3:0] {
    ST_IDLE        = 4'h0,
    ST_CS_SETUP    = 4'h1,
    ST_ADDR_SETUP  = 4'h3,
    ST_STROBE_HIGH = 4'h2,
    ST_STROBE_LOW  = 4'h6,
    ST_XFER_SETUP  = 4'h7,
    ST_XFER_LOW    = 4'h5,
    ST_READ_SETUP  = 4'h4,
    ST_READ_LOW    = 4'hc,
    ST_READ_HIGH   = 4'hd
  } ctrl_state_t;

endpackage

//--- src/serial_voice_rom_reader.sv
// Purpose: Read side of a 1M x 1 serial mask ROM
// Assumes: Pins synchronous to clk_sys, slower than two cycles per level
// Notes:   Contents are a fixed function of the address
//
// How it works
// - Ten horizontal address bits arrive serially
// - Ten vertical address bits arrive serially
// - Horizontal strobe shifts in one horizontal bit
// - Vertical strobe shifts in one vertical bit
// - Transfer strobe fall loads both into counter
// - Read clock fall reads bit to output
// - Each read advances counter by one
// - Read clock alone keeps bits streaming
// - Output floats when read clock or select high
// - Output holds bit while read clock low
// - Deselect ignores all strobes and clocks
// - Only selected device drives shared line
// - 1024 by 1024 bits, all addressable
`timescale 1ns/100ps
module serial_voice_rom_reader
  import rom_reader_pkg::*;
#(
  parameter int                DEV_INDEX = 0,
  parameter logic [ADDR_W-1:0] ROM_SEED  = 20'h6c3a9
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Pins
  rom_link.device  link
);

  // ==========================================================
  // Storage contents
  // Mask contents modelled as a parity hash; no array needed
  function automatic logic rom_bit(input logic [ADDR_W-1:0] a);
    rom_bit = ^(a & ROM_SEED) ^ a[HALF_W];
  endfunction

  // ==========================================================
  // State
  logic [HALF_W-1:0] horiz_addr_bits;
  logic [HALF_W-1:0] vert_addr_bits;
  logic [ADDR_W-1:0] counter;
  logic              data_bit;
  logic              bit_held;
  logic [ADDR_W-1:0] next_counter;
  logic              next_data_bit;
  logic              next_bit_held;
  logic              selected;
  logic              hs_rise;
  logic              vs_rise;
  logic              tas_fall;
  logic              rd_fall;

  // ==========================================================
  // Edge detection
  // Low-active pins enter inverted, so every finder idles low
  assign selected = !link.cs_n[DEV_INDEX];

  pin_rise u_hs_rise (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .pin     (link.horiz_addr_strobe),
    .enable  (selected),
    .rise    (hs_rise)
  );

  pin_rise u_vs_rise (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .pin     (link.vert_addr_strobe),
    .enable  (selected),
    .rise    (vs_rise)
  );

  pin_rise u_tas_fall (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .pin     (!link.addr_transfer_strobe_n),
    .enable  (selected),
    .rise    (tas_fall)
  );

  pin_rise u_rd_fall (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .pin     (!link.read_clock_n),
    .enable  (selected),
    .rise    (rd_fall)
  );

  // ==========================================================
  // Address halves
  addr_half_shift #(
    .WIDTH (HALF_W)
  ) u_horiz_shift (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .shift   (hs_rise),
    .bit_in  (link.horiz_serial_addr_in),
    .value   (horiz_addr_bits)
  );

  addr_half_shift #(
    .WIDTH (HALF_W)
  ) u_vert_shift (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .shift   (vs_rise),
    .bit_in  (link.vert_serial_addr_in),
    .value   (vert_addr_bits)
  );

  // ==========================================================
  // Counter and read
  always_comb begin
    next_counter  = counter;
    next_data_bit = data_bit;
    next_bit_held = bit_held;
    if (link.read_clock_n || !selected) begin
      next_bit_held = 1'b0;
    end
    if (rd_fall) begin
      next_data_bit = rom_bit(counter);
      next_bit_held = 1'b1;
      next_counter  = counter + 20'h00001;
    end
    // A load landing on a read edge wins, so the new address is never skipped
    if (tas_fall) begin
      next_counter = {vert_addr_bits, horiz_addr_bits};
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      counter  <= ADDR_RST;
      data_bit <= 1'b0;
      bit_held <= 1'b0;
    end else begin
      counter  <= next_counter;
      data_bit <= next_data_bit;
      bit_held <= next_bit_held;
    end
  end

  // ==========================================================
  // Output drive
  assign link.dout_o[DEV_INDEX]  = data_bit;
  assign link.dout_oe[DEV_INDEX] = selected && !link.read_clock_n && bit_held;

endmodule

// ==========================================================
// Gated rising-edge finder for one pin
module pin_rise (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rstn,
  // Pin, high when asserted, and its gate
  input  wire logic pin,
  input  wire logic enable,
  // Edge
  output wire logic rise
);
  logic prev;
  logic next_prev;

  // Tracked even while gated off, so reselecting never fakes an edge
  always_comb begin
    next_prev = pin;
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      prev <= 1'b0;
    end else begin
      prev <= next_prev;
    end
  end

  assign rise = enable && pin && !prev;
endmodule

// ==========================================================
// Serial shifter for one address half
module addr_half_shift #(
  parameter int WIDTH = 10
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rstn,
  // Serial input
  input  wire logic             shift,
  input  wire logic             bit_in,
  // Assembled half
  output wire logic [WIDTH-1:0] value
);
  logic [WIDTH-1:0] bits;
  logic [WIDTH-1:0] next_bits;

  // Enters at the top, so after WIDTH shifts the first bit sits at bit 0
  always_comb begin
    next_bits = bits;
    if (shift) begin
      next_bits = {bit_in, bits[WIDTH-1:1]};
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      bits <= '0;
    end else begin
      bits <= next_bits;
    end
  end

  assign value = bits;
endmodule

//--- testbench/rom_link_checker.sv
// Purpose: Concurrent checks on the ROM pin bundle
// Assumes: Two devices on one data line, one clk_sys domain
// Notes:   Sees link signals only, no internal state
`timescale 1ns/100ps
module rom_link_checker #(
  parameter int N_DEV = 2
) (
  // Clock and reset
  input wire logic             clk_sys,
  input wire logic             rstn,
  // Controller pins
  input wire logic             horiz_addr_strobe,
  input wire logic             vert_addr_strobe,
  input wire logic             addr_transfer_strobe_n,
  input wire logic             read_clock_n,
  input wire logic [N_DEV-1:0] cs_n,
  // Device pins
  input wire logic             dout_o  [N_DEV],
  input wire logic             dout_oe [N_DEV]
);
  logic       strobe_prev;
  logic [4:0] strobe_cnt;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);

  // ==========================================================
  // Strobe rises since last transfer; a short shift loads a stale half
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      strobe_prev <= 1'b0;
      strobe_cnt  <= 5'h00;
    end else begin
      strobe_prev <= horiz_addr_strobe;
      if ($fell(addr_transfer_strobe_n)) begin
        strobe_cnt <= 5'h00;
      end else if (horiz_addr_strobe && !strobe_prev) begin
        strobe_cnt <= strobe_cnt + 5'h01;
      end
    end
  end

  // ==========================================================
  // Assertions
  oe_float_a: assert property (dout_oe[0] |-> !read_clock_n && !cs_n[0])
    else $error("device 0 drives with read clock or select high");
  deselect_quiet_a: assert property (cs_n[1] |-> !dout_oe[1])
    else $error("deselected device 1 drives the line");
  one_driver_a: assert property (!(dout_oe[0] && dout_oe[1]))
    else $error("two devices drive the data line");
  one_select_a: assert property ($countones(~cs_n) <= 1)
    else $error("more than one device selected");
  read_answer_a: assert property ($fell(read_clock_n) && !cs_n[0] |-> ##[1:2] dout_oe[0])
    else $error("no output after read clock fall");
  bit_hold_a: assert property (dout_oe[0] && $past(dout_oe[0]) |-> $stable(dout_o[0]))
    else $error("output bit changed while read clock low");
  shift_count_a: assert property ($fell(addr_transfer_strobe_n) |-> strobe_cnt == 5'h0a)
    else $error("transfer without ten address strobes");
  strobe_pair_a: assert property (horiz_addr_strobe |-> vert_addr_strobe && !(&cs_n))
    else $error("address strobes apart or unselected");

  // ==========================================================
  // Covers
  cover property ($fell(addr_transfer_strobe_n));
  cover property ($fell(read_clock_n) && !cs_n[0]);
  cover property (dout_oe[1]);
endmodule

//--- testbench/serial_voice_rom_reader_bench.sv
// Purpose: Bench for two ROM devices sharing a line with one controller
// Assumes: Devices hold different fixed contents
// Notes:   Small FIFO so a stall fills it within a few bytes
`timescale 1ns/100ps
module serial_voice_rom_reader_bench
  import rom_reader_pkg::*;
;
  localparam logic [19:0] SEED0 = 20'h6c3a9;
  localparam logic [19:0] SEED1 = 20'h3b5e1;

  logic        clk_sys   = 1'b0;
  logic        rstn      = 1'b0;
  logic        cmd_valid = 1'b0;
  logic [19:0] cmd_addr  = 20'h00000;
  logic [15:0] cmd_len   = 16'h0000;
  logic [0:0]  cmd_dev   = 1'b0;
  logic        out_ready = 1'b0;
  logic        stall     = 1'b1;
  logic        cmd_ready;
  logic        out_valid;
  logic [7:0]  out_data;
  logic        busy;
  logic [7:0]  exp_q [$];
  logic [19:0] addr_q [$];
  logic [9:0]  hsh = 10'h000;
  logic [9:0]  vsh = 10'h000;
  logic        hprev = 1'b0;
  logic        vprev = 1'b0;
  logic        tprev = 1'b1;
  int          n_fail = 0;
  int          checks = 0;
  int          n;

  always #5 clk_sys = ~clk_sys;

  rom_link #(.N_DEV(2)) link ();
  serial_voice_rom_reader u_serial_voice_rom_reader (
    .clk_sys(clk_sys), .rstn(rstn), .link(link.device));
  serial_voice_rom_reader #(.DEV_INDEX(1), .ROM_SEED(SEED1)) u_serial_voice_rom_reader_1 (
    .clk_sys(clk_sys), .rstn(rstn), .link(link.device));
  rom_playback_ctrl #(.N_DEV(2), .FIFO_DEPTH(4)) u_rom_playback_ctrl (
    .clk_sys(clk_sys), .rstn(rstn), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_addr(cmd_addr), .cmd_len(cmd_len), .cmd_dev(cmd_dev), .out_valid(out_valid),
    .out_ready(out_ready), .out_data(out_data), .busy(busy), .link(link.controller));
  rom_link_checker u_rom_link_checker (
    .clk_sys(clk_sys), .rstn(rstn), .horiz_addr_strobe(link.horiz_addr_strobe),
    .vert_addr_strobe(link.vert_addr_strobe), .addr_transfer_strobe_n(link.addr_transfer_strobe_n),
    .read_clock_n(link.read_clock_n), .cs_n(link.cs_n), .dout_o(link.dout_o), .dout_oe(link.dout_oe));

  // ==========================================================
  // Tasks
  function automatic logic rom_bit(input logic [19:0] seed, input logic [19:0] a);
    return ^(a & seed) ^ a[10];
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t ns: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Notes expected bytes, then offers the command until taken
  task automatic run_cmd(input logic [19:0] a, input logic [15:0] len, input logic [0:0] d);
    logic [19:0] p;
    logic [7:0]  b;
    p = a;
    addr_q.push_back(a);
    for (int k = 0; k < len; k++) begin
      for (int i = 0; i < 8; i++) begin
        b[i] = rom_bit(d[0] ? SEED1 : SEED0, p);
        p    = p + 20'h00001;
      end
      exp_q.push_back(b);
    end
    @(posedge clk_sys);
    #1;
    cmd_valid = 1'b1;
    cmd_addr  = a;
    cmd_len   = len;
    cmd_dev   = d;
    do @(posedge clk_sys); while (cmd_ready !== 1'b1);
    #1;
    cmd_valid = 1'b0;
    check(32'({cmd_ready, busy, link.cs_n}), 32'({1'b0, 1'b1, ~(2'b01 << d)}));
  endtask

  // ==========================================================
  // Sink with random back-pressure
  always @(posedge clk_sys) begin
    #1;
    out_ready = stall ? 1'b0 : 1'($urandom_range(0, 1));
  end

  // ==========================================================
  // Watchers: byte stream and address pins
  always @(posedge clk_sys) begin
    if (rstn && out_valid === 1'b1 && out_ready === 1'b1) begin
      if (exp_q.size() == 0)
        check(32'(exp_q.size()), 32'h1);
      else
        check(32'(out_data), 32'(exp_q.pop_front()));
    end
    if (rstn) begin
      if (link.horiz_addr_strobe && !hprev) hsh = {link.horiz_serial_addr_in, hsh[9:1]};
      if (link.vert_addr_strobe && !vprev) vsh = {link.vert_serial_addr_in, vsh[9:1]};
      if (!link.addr_transfer_strobe_n && tprev && addr_q.size() > 0)
        check(32'({vsh, hsh}), 32'(addr_q.pop_front()));
    end
    hprev = link.horiz_addr_strobe;
    vprev = link.vert_addr_strobe;
    tprev = link.addr_transfer_strobe_n;
  end

  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(32'h1d256407));
    repeat (5) @(posedge clk_sys);
    #1;
    rstn  = 1'b1;
    stall = 1'b0;
    run_cmd(20'($urandom), 16'h0002, 1'b0);
    run_cmd(20'h003fc, 16'h0001, 1'b1);
    run_cmd(20'hffffc, 16'h0001, 1'b0);
    run_cmd(20'h12345, 16'h0000, 1'b1);
    for (int j = 0; j < 3; j++) begin
      run_cmd(20'($urandom), 16'($urandom_range(1, 2)), 1'($urandom));
    end
    // Full FIFO must hold the read clock high, line floats to pull-up
    stall = 1'b1;
    run_cmd(20'($urandom), 16'h0006, 1'b1);
    repeat (12000) @(posedge clk_sys);
    n = 0;
    repeat (300) begin
      @(posedge clk_sys);
      if (link.read_clock_n !== 1'b1) n++;
    end
    check(32'(n), 32'h0);
    check(32'(link.data_line), 32'h1);
    stall = 1'b0;
    repeat (20000) begin
      @(posedge clk_sys);
      if (busy === 1'b0 && exp_q.size() == 0) break;
    end
    check(32'(exp_q.size()), 32'h0);
    check(32'(addr_q.size()), 32'h0);
    give_verdict();
  end

  // Hang guard, well past the longest expected run
  initial begin
    repeat (90000) @(posedge clk_sys);
    n_fail++;
    give_verdict();
  end
endmodule
